// file: design/oad_pkg.sv
// Constants, types and field layouts for the operand address format decoder.
// Assumes a single 50 MHz processor clock shared with fetch and address generation.
// Operation
// RQ1: Mode 01 with zero source field is direct; long segmented uses flagged segment word.
// RQ2: Mode 01 with nonzero source field is indexed; flat form adds one address word.
// RQ3: Short segmented form is one word: clear top bit, segment, 8-bit offset.
// RQ4: Relative address is displacement plus address of the following instruction.
// RQ5: Based needs nonzero base; displacement word; based-indexed word holds index in 11:8.
// RQ6: Immediate data words follow all destination address extension words.
// RQ7: Length comes from format class F1-F9 and the addressing mode row.
// RQ8: Register, indirect and immediate lengths follow the per-class byte table.
// RQ9: Direct, indexed, relative and based lengths follow the per-class byte table.
// RQ10: Word/byte bit set selects word operation, clear selects byte operation.
// RQ11: Mode field is two bits; register, code, number and index fields four bits.
// RQ12: Length and extracted fields are presented when the final extension word is taken.
package oad_pkg;

  localparam int OAD_WORD_W   = 16;
  localparam int OAD_FIELD_W  = 4;
  localparam int OAD_MODE_W   = 2;
  localparam int OAD_LEN_W    = 4;

  // First word fields.
  localparam int OAD_MODE_HI  = 15;
  localparam int OAD_MODE_LO  = 14;
  localparam int OAD_WB_BIT   = 8;
  localparam int OAD_SRC_HI   = 7;
  localparam int OAD_SRC_LO   = 4;
  localparam int OAD_DST_HI   = 3;
  localparam int OAD_DST_LO   = 0;

  // Extension word fields.
  localparam int OAD_SEG_FLAG = 15;
  localparam int OAD_SEG_HI   = 14;
  localparam int OAD_SEG_LO   = 8;
  localparam int OAD_OFS_HI   = 7;
  localparam int OAD_OFS_LO   = 0;
  localparam int OAD_X_HI     = 11;
  localparam int OAD_X_LO     = 8;

  localparam logic [1:0] OAD_MODE_EXT = 2'h1;
  localparam logic [3:0] OAD_REG_NONE = 4'h0;

  // Instruction lengths in bytes.
  localparam logic [3:0] OAD_LEN_0 = 4'h0;
  localparam logic [3:0] OAD_LEN_2 = 4'h2;
  localparam logic [3:0] OAD_LEN_4 = 4'h4;
  localparam logic [3:0] OAD_LEN_6 = 4'h6;
  localparam logic [3:0] OAD_LEN_8 = 4'h8;

  // Format classes F1..F9.
  typedef enum logic [3:0] {
    OAD_F1 = 4'h1, OAD_F2 = 4'h2, OAD_F3 = 4'h3, OAD_F4 = 4'h4, OAD_F5 = 4'h5,
    OAD_F6 = 4'h6, OAD_F7 = 4'h7, OAD_F8 = 4'h8, OAD_F9 = 4'h9
  } oad_fmt_e;

  // Addressing mode row; imm_* kinds only matter for the length table.
  typedef enum logic [2:0] {
    OAD_K_REG_IND = 3'h0,
    OAD_K_IMM_WB  = 3'h1,
    OAD_K_IMM_L   = 3'h2,
    OAD_K_DIRIDX  = 3'h3,
    OAD_K_REL     = 3'h4,
    OAD_K_BASED   = 3'h5,
    OAD_K_BIDX    = 3'h6
  } oad_kind_e;

  typedef enum logic [1:0] {
    OAD_S_IDLE = 2'h0,
    OAD_S_EXT1 = 2'h1,
    OAD_S_EXT2 = 2'h2
  } oad_state_e;

  // Instruction start from fetch.
  typedef struct packed {
    logic [15:0] word;
    logic [15:0] pc;
    oad_fmt_e    fmt;
    oad_kind_e   kind;
    logic        seg_mode;
    logic [7:0]  rel_disp;
  } oad_start_s;

  // Decoded result to address generation.
  typedef struct packed {
    logic        direct;
    logic        indexed;
    logic        relative;
    logic        based;
    logic        based_idx;
    logic        long_seg;
    logic        word_op;
    logic [1:0]  mode;
    logic [3:0]  src_reg;
    logic [3:0]  idx_reg;
    logic [6:0]  segment;
    logic [15:0] offset;
    logic [15:0] operand_addr;
    logic [3:0]  length;
  } oad_result_s;

endpackage : oad_pkg

// file: design/oad_decoder.sv
// Operand address format decoder: takes the first instruction word plus its
// address extension words and presents extracted fields and the length.
// Assumes fetch supplies one word per valid pulse in instruction order.
module oad_decoder (
  input  wire logic               ref_clk,
  input  wire logic               resetn,
  input  wire logic               start_valid,
  input  oad_pkg::oad_start_s     start_in,
  input  wire logic               ext_valid,
  input  wire logic [15:0]        ext_word,
  output logic                    busy,
  output logic                    result_valid,
  output logic                    format_error,
  output oad_pkg::oad_result_s    result
);
  import oad_pkg::*;

  // ---------------------------------------------------------------------------
  // First word decode
  // ---------------------------------------------------------------------------
  wire logic [1:0] mode_f  = start_in.word[OAD_MODE_HI:OAD_MODE_LO];   // RQ11
  wire logic [3:0] src_f   = start_in.word[OAD_SRC_HI:OAD_SRC_LO];     // RQ11
  wire logic       word_op = start_in.word[OAD_WB_BIT];                // RQ10
  wire logic       is_ext  = (start_in.kind == OAD_K_DIRIDX);
  wire logic       is_dir  = is_ext && (mode_f == OAD_MODE_EXT) && (src_f == OAD_REG_NONE); // RQ1
  wire logic       is_idx  = is_ext && (mode_f == OAD_MODE_EXT) && (src_f != OAD_REG_NONE); // RQ2
  wire logic       is_bas  = (start_in.kind == OAD_K_BASED);
  wire logic       is_bx   = (start_in.kind == OAD_K_BIDX);
  wire logic       is_rel  = (start_in.kind == OAD_K_REL);
  wire logic       bad_base = (is_bas || is_bx) && (src_f == OAD_REG_NONE); // RQ5
  wire logic       need_ext = is_dir || is_idx || is_bas || is_bx;

  logic [3:0] len_sel;

  // Relative target: next instruction address plus signed displacement.
  wire logic [15:0] rel_len  = {12'h000, len_sel};
  wire logic [15:0] rel_disp = {{8{start_in.rel_disp[7]}}, start_in.rel_disp};
  wire logic [15:0] rel_addr = start_in.pc + rel_len + rel_disp;          // RQ4

  // ---------------------------------------------------------------------------
  // Length table
  // ---------------------------------------------------------------------------
  always_comb begin                                                       // RQ7
    len_sel = OAD_LEN_0;
    unique case (start_in.kind)
      OAD_K_REG_IND: begin                                                // RQ8
        if (start_in.fmt inside {OAD_F1, OAD_F2, OAD_F7, OAD_F8}) len_sel = OAD_LEN_2;
        else if (start_in.fmt inside {OAD_F5, OAD_F6}) len_sel = OAD_LEN_4;
      end
      OAD_K_IMM_WB: begin                                                 // RQ8
        if (start_in.fmt inside {OAD_F1, OAD_F2}) len_sel = OAD_LEN_4;
        else if (start_in.fmt inside {OAD_F3, OAD_F9}) len_sel = OAD_LEN_2;
      end
      OAD_K_IMM_L: begin                                                  // RQ8
        if (start_in.fmt inside {OAD_F1, OAD_F2}) len_sel = OAD_LEN_6;
      end
      OAD_K_DIRIDX: begin                                                 // RQ9
        if (start_in.fmt inside {OAD_F1, OAD_F2, OAD_F7}) len_sel = OAD_LEN_4;
        else if (start_in.fmt inside {OAD_F5, OAD_F6}) len_sel = OAD_LEN_6;
      end
      OAD_K_REL: begin                                                    // RQ9
        if (start_in.fmt == OAD_F3) len_sel = OAD_LEN_2;
        else if (start_in.fmt == OAD_F4) len_sel = OAD_LEN_4;
      end
      OAD_K_BASED, OAD_K_BIDX: begin                                      // RQ9
        if (start_in.fmt == OAD_F4) len_sel = OAD_LEN_4;
      end
      default: len_sel = OAD_LEN_0;
    endcase
  end

  // ---------------------------------------------------------------------------
  // Extension word decode
  // ---------------------------------------------------------------------------
  oad_state_e  state_q, state_d;
  oad_result_s res_q, res_d;
  logic        rv_q, err_q;
  logic        rv_d, err_d;

  // Immediate data that follows a direct/indexed destination is left to fetch:
  // the decoder finishes on the last address word so data comes after it.
  logic start_seg_q;                                                      // RQ6

  wire logic       seg_flag  = ext_word[OAD_SEG_FLAG];
  wire logic [6:0] seg_num   = ext_word[OAD_SEG_HI:OAD_SEG_LO];
  wire logic [7:0] ofs_short = ext_word[OAD_OFS_HI:OAD_OFS_LO];
  wire logic       lowz      = (ofs_short == 8'h00);
  wire logic       bx_ok     = (ext_word[15:12] == 4'h0) && lowz;         // RQ5

  always_comb begin
    state_d = state_q;
    res_d   = res_q;
    rv_d    = 1'b0;
    err_d   = 1'b0;
    unique case (state_q)
      OAD_S_IDLE: begin
        if (start_valid) begin
          res_d           = '0;
          res_d.mode      = mode_f;
          res_d.src_reg   = src_f;
          res_d.word_op   = word_op;
          res_d.direct    = is_dir;
          res_d.indexed   = is_idx;
          res_d.relative  = is_rel;
          res_d.based     = is_bas;
          res_d.based_idx = is_bx;
          res_d.length    = len_sel;
          if (is_rel) res_d.operand_addr = rel_addr;                      // RQ4
          if (bad_base || (len_sel == OAD_LEN_0)) begin
            err_d = 1'b1;
          end else if (need_ext) begin
            state_d = OAD_S_EXT1;
          end else begin
            rv_d = 1'b1;                                                  // RQ12
          end
        end
      end
      OAD_S_EXT1: begin
        if (ext_valid) begin
          if ((res_q.direct || res_q.indexed) && start_seg_q) begin
            res_d.segment = seg_num;
            if (seg_flag && lowz) begin                                   // RQ1
              res_d.long_seg = 1'b1;
              res_d.length   = res_q.length + OAD_LEN_2;                  // RQ9
              state_d        = OAD_S_EXT2;
            end else if (!seg_flag) begin                                 // RQ3
              res_d.offset = {8'h00, ofs_short};
              rv_d         = 1'b1;
              state_d      = OAD_S_IDLE;
            end else begin
              err_d   = 1'b1;
              state_d = OAD_S_IDLE;
            end
          end else if (res_q.based_idx) begin
            res_d.idx_reg = ext_word[OAD_X_HI:OAD_X_LO];                  // RQ5
            rv_d          = bx_ok;
            err_d         = !bx_ok;
            state_d       = OAD_S_IDLE;
          end else begin
            res_d.offset = ext_word;                                      // RQ2
            rv_d         = 1'b1;
            state_d      = OAD_S_IDLE;
          end
          if (res_q.indexed) res_d.idx_reg = res_q.src_reg;               // RQ2
        end
      end
      OAD_S_EXT2: begin
        if (ext_valid) begin
          res_d.offset = ext_word;                                        // RQ1
          rv_d         = 1'b1;                                            // RQ12
          state_d      = OAD_S_IDLE;
        end
      end
      default: state_d = OAD_S_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      state_q     <= OAD_S_IDLE;
      res_q       <= '0;
      rv_q        <= 1'b0;
      err_q       <= 1'b0;
      start_seg_q <= 1'b0;
    end else begin
      state_q <= state_d;
      res_q   <= res_d;
      rv_q    <= rv_d;
      err_q   <= err_d;
      if (start_valid && (state_q == OAD_S_IDLE)) start_seg_q <= start_in.seg_mode;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) busy <= 1'b0;
    else busy <= (state_d != OAD_S_IDLE);
  end

  assign result_valid = rv_q;
  assign format_error = err_q;
  assign result       = res_q;

endmodule // oad_decoder

// file: dv/oad_decoder_props.sv
// Port checks for the operand address decoder.
// Assumes a bind onto oad_decoder; sees only its ports.
module oad_decoder_props (
  input wire logic            ref_clk,
  input wire logic            resetn,
  input wire logic            start_valid,
  input oad_pkg::oad_start_s  start_in,
  input wire logic            ext_valid,
  input wire logic [15:0]     ext_word,
  input wire logic            busy,
  input wire logic            result_valid,
  input wire logic            format_error,
  input oad_pkg::oad_result_s result
);
  timeunit 1ns;
  timeprecision 1ps;
  import oad_pkg::*;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  sequence s_take(oad_kind_e k);
    start_valid && !busy && start_in.kind == k;
  endsequence
  sequence s_seg;
    s_take(OAD_K_DIRIDX) ##0 start_in.seg_mode ##1 ext_valid && busy;
  endsequence
  a_ext_wait: assert property (s_take(OAD_K_DIRIDX) |=> busy) else $error("no wait");
  a_short_done: assert property (s_take(OAD_K_REG_IND) |=> !busy && (result_valid || format_error))
    else $error("late");
  a_long_pair: assert property (s_seg ##0 ext_word[15] && ext_word[7:0] == 8'h00 |=> busy && !result_valid)
    else $error("long");
  a_short_seg: assert property (s_seg ##0 !ext_word[15] |=> result_valid &&
    result.segment == $past(ext_word[14:8]) && result.offset == {8'h00, $past(ext_word[7:0])}) else $error("short");
  a_rel_addr: assert property (s_take(OAD_K_REL) |=> format_error ||
    result.operand_addr == 16'($past(start_in.pc) + {{8{$past(start_in.rel_disp[7])}}, $past(start_in.rel_disp)}
    + result.length)) else $error("rel");
  a_bx_index: assert property (s_take(OAD_K_BIDX) ##0 start_in.word[7:4] != 4'h0 ##1 busy && ext_valid &&
    (ext_word & 16'hF0FF) == 16'h0000 |=> result_valid && result.idx_reg == $past(ext_word[11:8])) else $error("bx");
  a_zero_base: assert property (s_take(OAD_K_BASED) ##0 start_in.word[7:4] == 4'h0 |-> ##[1:3] format_error)
    else $error("base");
  a_reg_len: assert property (s_take(OAD_K_REG_IND) ##0 start_in.fmt inside {OAD_F5, OAD_F6} |=>
    result.length == 4'h4 && result.word_op == $past(start_in.word[8])) else $error("len");
  a_idle_quiet: assert property (!busy && !start_valid |=> !result_valid && !format_error) else $error("stray");
endmodule // oad_decoder_props

// file: dv/oad_fetch_model.sv
// Fetch-stage stand-in feeding first words and extension words.
// Assumes the decoder samples on the rising edge; this side drives on the falling edge.
module oad_fetch_model (
  input  wire logic           ref_clk,
  output logic                start_valid,
  output oad_pkg::oad_start_s start_in,
  output logic                ext_valid,
  output logic [15:0]         ext_word
);
  timeunit 1ns;
  timeprecision 1ps;
  import oad_pkg::*;
  initial begin
    start_valid = 1'b0;
    start_in = '0;
    ext_valid = 1'b0;
    ext_word = 16'hA5A5;
  end
  // Words leave in order; the second one comes a cycle late to model a slow fetch.
  task automatic send(input oad_start_s s, input logic [15:0] w0, w1, input int n);
    @(negedge ref_clk);
    start_valid = 1'b1;
    start_in = s;
    @(negedge ref_clk);
    start_valid = 1'b0;
    start_in = oad_start_s'(~s);
    for (int i = 0; i < n; i++) begin
      repeat (i) @(negedge ref_clk);
      ext_valid = 1'b1;
      ext_word = i ? w1 : w0;
      @(negedge ref_clk);
      ext_valid = 1'b0;
      ext_word = ~ext_word;
    end
  endtask
endmodule // oad_fetch_model

// file: dv/operand_address_format_decoder_tb.sv
// Self-checking bench for the operand address decoder.
// Assumes oad_fetch_model drives the inputs and oad_decoder_props is bound to the design.
module operand_address_format_decoder_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import oad_pkg::*;
  logic        ref_clk, resetn, start_valid, ext_valid, busy, result_valid, format_error;
  logic [15:0] ext_word;
  oad_start_s  start_in;
  oad_result_s result;
  int          failures, n_tests, n_rv, n_fe, cycles;
  oad_fetch_model fm (.*);
  oad_decoder dut (.*);
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  always @(negedge ref_clk) begin
    n_rv += int'(result_valid === 1'b1);
    n_fe += int'(format_error === 1'b1);
  end
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 2000) begin
      failures++;
      report_and_stop();
    end
  end
  task automatic chk(input logic [47:0] got, exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic go(input oad_fmt_e f, oad_kind_e k, logic sg, logic [15:0] w, w0, w1, int n, logic [7:0] d);
    @(posedge ref_clk);
    n_rv = 0;
    n_fe = 0;
    fm.send('{word: w, pc: 16'h1000, fmt: f, kind: k, seg_mode: sg, rel_disp: d}, w0, w1, n);
  endtask
  task automatic err();
    @(posedge ref_clk);
    chk({n_fe[15:0], n_rv}, {16'h0001, 32'h0});
  endtask
  task automatic t_table();
    logic [47:0] fl = 48'h127856123912;
    logic [47:0] ln = 48'h222244442266;
    for (int i = 0; i < 12; i++) begin
      go(oad_fmt_e'(fl[47-4*i -: 4]), i < 6 ? OAD_K_REG_IND : i < 10 ? OAD_K_IMM_WB : OAD_K_IMM_L, 1'b0,
         i[0] ? 16'h8032 : 16'h8132, '0, '0, 0, '0);
      chk({result_valid, result.length, result.mode}, {1'b1, ln[47-4*i -: 4], 2'h2});
      chk(result.word_op, !i[0]);
    end
    $display("done: length table");
  endtask
  task automatic t_dirx();
    go(OAD_F1, OAD_K_DIRIDX, 1'b0, 16'h4102, 16'h0012, '0, 1, '0);
    chk({result_valid, result.direct, result.indexed, result.length, result.offset}, {3'h6, 4'h4, 16'h0012});
    go(OAD_F2, OAD_K_DIRIDX, 1'b1, 16'h4142, 16'h0312, '0, 1, '0);
    chk({result.indexed, result.idx_reg, result.segment, result.offset, result.length},
        {1'b1, 4'h4, 7'h03, 16'h0012, 4'h4});
    go(OAD_F1, OAD_K_DIRIDX, 1'b1, 16'h4102, 16'h8300, 16'h0012, 2, '0);
    chk({result_valid, result.long_seg, result.segment, result.offset, result.length},
        {2'h3, 7'h03, 16'h0012, 4'h6});
    go(OAD_F1, OAD_K_DIRIDX, 1'b1, 16'h4102, 16'h8301, 16'h0012, 2, '0);
    err();
    go(OAD_F1, OAD_K_DIRIDX, 1'b0, 16'h4102, 16'h0012, 16'h1234, 2, '0);
    @(posedge ref_clk);
    chk({n_rv, result.offset, result.length}, {32'h1, 16'h0012, 4'h4});
    $display("done: direct and indexed");
  endtask
  task automatic t_rel();
    go(OAD_F3, OAD_K_REL, 1'b0, 16'h3102, '0, '0, 0, 8'h06);
    chk({result_valid, result.relative, result.operand_addr, result.length}, {2'h3, 16'h1008, 4'h2});
    go(OAD_F4, OAD_K_REL, 1'b0, 16'h3102, '0, '0, 0, 8'hFE);
    chk({result_valid, result.operand_addr, result.length}, {1'b1, 16'h1002, 4'h4});
    go(OAD_F1, OAD_K_REL, 1'b0, 16'h3102, '0, '0, 0, 8'h06);
    err();
    $display("done: relative");
  endtask
  task automatic t_based();
    go(OAD_F4, OAD_K_BASED, 1'b0, 16'h3142, 16'h0012, '0, 1, '0);
    chk({result_valid, result.based, result.src_reg, result.length}, {2'h3, 4'h4, 4'h4});
    go(OAD_F4, OAD_K_BIDX, 1'b0, 16'h7142, 16'h0500, '0, 1, '0);
    chk({result_valid, result.based_idx, result.idx_reg, result.length}, {2'h3, 4'h5, 4'h4});
    go(OAD_F4, OAD_K_BIDX, 1'b0, 16'h7142, 16'h0501, '0, 1, '0);
    err();
    go(OAD_F4, OAD_K_BASED, 1'b0, 16'h3102, 16'h0012, '0, 1, '0);
    err();
    $display("done: based");
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    resetn = 1'b0;
    repeat (2) @(negedge ref_clk);
    resetn = 1'b1;
    t_table();
    t_dirx();
    t_rel();
    t_based();
    report_and_stop();
  end
endmodule // operand_address_format_decoder_tb
bind oad_decoder oad_decoder_props u_props (.*);
